// [rtl/bip_parser.sv]
/*
  Boot image block parser: takes the image byte stream read from serial
  memory, splits it into header, payload and trailer, assembles coefficient
  and data memory words, checks the trailer checksum and spots termination.
  Assumes the byte source is synchronous to mclk and the block kind for the
  block in progress is given on blk_kind while the header arrives.
*/
// Notes on behaviour
// - Coefficient word is four bytes, LSB first; only bits 27..0 meaningful.
// - Fourth coefficient byte lands in bits 31..24, earlier bytes lower.
// - Data memory word is six bytes, first byte holds bits 7..0.
// - Sixth data byte lands in bits 47..40, giving a 48-bit word.
// - Trailer at N+12: two zero bytes, checksum high, checksum low.
// - Checksum covers bytes 2 through N+11.
// - Coefficient payload starts at 12; N is four times word count.
// - Length field is 12 + payload + trailer; zero marks termination.
// - Termination block is 20 bytes: 0000, 001F, then sixteen zeros.
module bip_parser #(
  parameter int W     = bip_pkg::WORD_W,
  parameter int DEPTH = bip_pkg::FIFO_DEPTH
) (
  input  wire logic         mclk,        // System clock, 50 MHz.
  input  wire logic         rst_n,       // Asynchronous reset, active low.
  input  wire logic         in_valid,    // Image byte offered.
  input  wire logic [7:0]   in_byte,     // Image byte.
  output logic              in_ready,    // Parser takes the byte.
  input  wire logic         blk_kind,    // 0 coefficient block, 1 data block.
  output logic              word_valid,  // Assembled word available.
  output logic [W-1:0]      word_data,   // Assembled word.
  output logic              word_is_dmem,// Word belongs to data memory.
  input  wire logic         word_ready,  // Consumer takes the word.
  output logic              blk_done,    // Pulse: block trailer checked.
  output logic              sum_err,     // Pulse: checksum mismatch.
  output logic              fmt_err,     // Pulse: malformed block.
  output logic              image_done   // Level: termination seen.
);
  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    bip_pkg::bip_state_t st;
    logic [15:0]         idx;
    logic [15:0]         len;
    logic                kind;
    logic [2:0]          lane;
    logic [W-1:0]        acc;
    logic                push;
    logic [W-1:0]        push_data;
    logic                push_dmem;
    logic [15:0]         csum_rx;
    logic                blk_done;
    logic                sum_err;
    logic                fmt_err;
    logic                img_done;
    logic                rdy;
  } bip_st_t;

  bip_st_t     st_reg, st_next;
  logic [15:0] sum;
  logic        take;
  logic        sum_clr;
  logic        sum_add;
  logic [15:0] pay_end;
  logic [2:0]  lanes;
  logic        fifo_valid;
  logic [W:0]  fifo_data;

  bip_word_if #(.W(W+1)) wq ();

  // Back-pressure: a pending word stalls byte intake until the FIFO takes it.
  assign take     = in_valid & in_ready;
  assign in_ready = st_reg.rdy;
  assign wq.valid = st_reg.push;
  assign wq.data  = {st_reg.push_dmem, st_reg.push_data};

  // Payload ends where the length field less the trailer says.
  assign pay_end = st_reg.len - 16'(bip_pkg::TRAILER_BYTES);
  assign lanes   = st_reg.kind ? 3'(bip_pkg::DMEM_BYTES)
                               : 3'(bip_pkg::COEF_BYTES);
  assign sum_clr = (st_reg.st == bip_pkg::BIP_ST_HDR) && (st_reg.idx == 16'h0000);
  assign sum_add = take && (st_reg.idx >= 16'(bip_pkg::SUM_FIRST_IDX))
                   && (st_reg.st != bip_pkg::BIP_ST_TRL)
                   && (st_reg.st != bip_pkg::BIP_ST_TERM);

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    st_next.blk_done = 1'b0;
    st_next.sum_err  = 1'b0;
    st_next.fmt_err  = 1'b0;
    if (st_reg.push && wq.ready) begin
      st_next.push = 1'b0;
    end
    if (take) begin
      st_next.idx = st_reg.idx + 16'h0001;
      unique case (st_reg.st)
        bip_pkg::BIP_ST_HDR: begin
          if (st_reg.idx == 16'h0000) begin
            st_next.kind = blk_kind;
          end
          if (st_reg.idx == 16'(bip_pkg::LEN_HI_IDX)) begin
            st_next.len[15:8] = in_byte;
          end
          if (st_reg.idx == 16'(bip_pkg::LEN_LO_IDX)) begin
            st_next.len[7:0] = in_byte;
          end
          if (st_reg.idx == 16'(bip_pkg::HDR_BYTES - 1)) begin
            st_next.lane = 3'h0;
            st_next.acc  = '0;
            if (st_reg.len == bip_pkg::TERM_LEN) begin
              st_next.st = bip_pkg::BIP_ST_TERM;
            end else if (st_reg.len < 16'(bip_pkg::HDR_BYTES + bip_pkg::TRAILER_BYTES)) begin
              st_next.fmt_err = 1'b1;
              st_next.idx     = 16'h0000;
            end else begin
              st_next.st = bip_pkg::BIP_ST_PAY;
            end
          end
        end
        bip_pkg::BIP_ST_PAY: begin
          // Each byte fills the next higher lane, LSB first.
          st_next.acc[8*st_reg.lane +: 8] = in_byte;
          st_next.lane = st_reg.lane + 3'h1;
          if (st_reg.lane == lanes - 3'h1) begin
            st_next.lane      = 3'h0;
            st_next.acc       = '0;
            st_next.push      = 1'b1;
            st_next.push_dmem = st_reg.kind;
            st_next.push_data = st_reg.acc;
            st_next.push_data[8*st_reg.lane +: 8] = in_byte;
            if (!st_reg.kind) begin
              // Coefficient memory keeps only the valid low bits.
              st_next.push_data[W-1:bip_pkg::COEF_VALID_MSB+1] = '0;
            end
          end
          if (st_reg.idx == pay_end - 16'h0001) begin
            st_next.st = bip_pkg::BIP_ST_TRL;
            if (st_reg.lane != lanes - 3'h1) begin
              st_next.fmt_err = 1'b1;
            end
          end
        end
        bip_pkg::BIP_ST_TRL: begin
          // Trailer: 00, 00, checksum high, checksum low.
          if (st_reg.idx < pay_end + 16'h0002 && in_byte != 8'h00) begin
            st_next.fmt_err = 1'b1;
          end
          if (st_reg.idx == pay_end + 16'h0002) begin
            st_next.csum_rx[15:8] = in_byte;
          end
          if (st_reg.idx == pay_end + 16'h0003) begin
            st_next.blk_done = 1'b1;
            st_next.sum_err  = ({st_reg.csum_rx[15:8], in_byte} != sum);
            st_next.st       = bip_pkg::BIP_ST_HDR;
            st_next.idx      = 16'h0000;
          end
        end
        bip_pkg::BIP_ST_TERM: begin
          // Bytes 12..19 of the termination block must all be zero.
          if (in_byte != 8'h00) begin
            st_next.fmt_err = 1'b1;
          end
          if (st_reg.idx == 16'(bip_pkg::TERM_BYTES - 1)) begin
            st_next.st       = bip_pkg::BIP_ST_DONE;
            st_next.img_done = 1'b1;
          end
        end
        bip_pkg::BIP_ST_DONE: begin
          st_next.st = bip_pkg::BIP_ST_DONE;
        end
        default: begin
          st_next.st = bip_pkg::BIP_ST_HDR;
        end
      endcase
      // Header bytes 0..3 of a termination block read 0000 then 001F.
      if (st_reg.st == bip_pkg::BIP_ST_HDR && st_reg.len == bip_pkg::TERM_LEN
          && st_reg.idx == 16'(bip_pkg::HDR_BYTES - 1)) begin
        st_next.fmt_err = st_reg.csum_rx != bip_pkg::TERM_TAG;
      end
      // Once either of the first two bytes is seen to be nonzero the marker must survive.
      if (st_reg.st == bip_pkg::BIP_ST_HDR && st_reg.idx < 16'h0004
          && !(st_reg.idx >= 16'h0002 && st_reg.csum_rx == 16'hFFFF)) begin
        st_next.csum_rx = {st_reg.csum_rx[7:0], in_byte};
      end
      if (st_reg.st == bip_pkg::BIP_ST_HDR && st_reg.idx == 16'h0001
          && {st_reg.csum_rx[7:0], in_byte} != 16'h0000) begin
        st_next.csum_rx = 16'hFFFF;
      end
    end
    // Intake ready is kept in a flop so the port comes straight from a register.
    st_next.rdy = ~st_next.push & (st_next.st != bip_pkg::BIP_ST_DONE);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg     <= '0;
      st_reg.st  <= bip_pkg::BIP_ST_HDR;
      st_reg.rdy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  bip_sum u_sum (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .clr     (sum_clr),
    .add     (sum_add),
    .byte_in (in_byte),
    .sum     (sum)
  );

  bip_fifo #(.W(W+1), .DEPTH(DEPTH)) u_fifo (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .wr       (wq),
    .rd_valid (fifo_valid),
    .rd_ready (word_ready),
    .rd_data  (fifo_data)
  );

  assign word_valid   = fifo_valid;
  assign word_data    = fifo_data[W-1:0];
  assign word_is_dmem = fifo_data[W];
  assign blk_done     = st_reg.blk_done;
  assign sum_err      = st_reg.sum_err;
  assign fmt_err      = st_reg.fmt_err;
  assign image_done   = st_reg.img_done;
endmodule // bip_parser

// [common/bip_pkg.sv]
/*
  Shared constants and types of the boot image block parser.
  Assumes a single 50 MHz system clock and an asynchronous active-low reset.
*/
package bip_pkg;

  // ---------------------------------------------------------------------
  // Image layout
  // ---------------------------------------------------------------------
  localparam int unsigned HDR_BYTES      = 12;
  localparam int unsigned LEN_HI_IDX     = 8;
  localparam int unsigned LEN_LO_IDX     = 9;
  localparam int unsigned SUM_FIRST_IDX  = 2;
  localparam int unsigned TRAILER_BYTES  = 4;
  localparam int unsigned COEF_BYTES     = 4;
  localparam int unsigned DMEM_BYTES     = 6;
  localparam int unsigned COEF_VALID_MSB = 27;
  localparam int unsigned TERM_BYTES     = 20;
  localparam logic [15:0] TERM_TAG       = 16'h001F;
  localparam logic [15:0] TERM_LEN       = 16'h0000;
  localparam int unsigned WORD_W         = 48;
  localparam int unsigned FIFO_DEPTH     = 8;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    BIP_KIND_COEF = 2'h0,
    BIP_KIND_DMEM = 2'h1
  } bip_kind_t;

  typedef enum logic [4:0] {
    BIP_ST_HDR  = 5'h01,
    BIP_ST_PAY  = 5'h02,
    BIP_ST_TRL  = 5'h04,
    BIP_ST_TERM = 5'h08,
    BIP_ST_DONE = 5'h10
  } bip_state_t;

endpackage : bip_pkg

// [common/bip_word_if.sv]
/*
  Word stream carrier between the parser core and its output FIFO.
  Assumes both ends sit in the one system clock domain.
*/
interface bip_word_if #(
  parameter int W = 50
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : bip_word_if

// [rtl/bip_fifo.sv]
/*
  Small synchronous FIFO with valid and ready on both sides.
  Assumes one clock; the read data is the storage entry at the read pointer, selected without an output register.
*/
module bip_fifo #(
  parameter int W     = 50,
  parameter int DEPTH = 8
) (
  input  wire logic mclk,     // System clock.
  input  wire logic rst_n,    // Asynchronous reset, active low.
  bip_word_if.snk   wr,       // Filling side.
  output logic         rd_valid, // Head word is valid.
  input  wire logic    rd_ready, // Drain side accepts the head.
  output logic [W-1:0] rd_data   // Head word.
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          ne;
  } bip_fifo_st_t;

  bip_fifo_st_t  st_reg, st_next;
  logic [W-1:0]  mem [DEPTH];
  logic          do_wr, do_rd;

  assign wr.ready = (st_reg.cnt != (AW+1)'(DEPTH));
  assign rd_valid = st_reg.ne;
  assign rd_data  = mem[st_reg.rp];
  assign do_wr    = wr.valid & wr.ready;
  assign do_rd    = rd_valid & rd_ready;

  always_comb begin
    st_next = st_reg;
    if (do_wr) begin
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (do_rd) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    st_next.ne  = (st_next.cnt != '0);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[st_reg.wp] <= wr.data;
    end
  end
endmodule // bip_fifo

// [rtl/bip_sum.sv]
/*
  Running 16-bit byte sum over the checksummed span of a block.
  The exact checksum algorithm is not defined here; a plain modular byte sum is used.
*/
module bip_sum (
  input  wire logic        mclk,   // System clock.
  input  wire logic        rst_n,  // Asynchronous reset, active low.
  input  wire logic        clr,    // Restart the sum.
  input  wire logic        add,    // Add byte_in this cycle.
  input  wire logic [7:0]  byte_in,// Byte to add.
  output logic      [15:0] sum     // Running sum.
);
  typedef struct packed {
    logic [15:0] acc;
  } bip_sum_st_t;

  bip_sum_st_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (clr) begin
      st_next.acc = 16'h0000;
    end else if (add) begin
      st_next.acc = st_reg.acc + {8'h00, byte_in};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sum = st_reg.acc;
endmodule // bip_sum

// [tb/bip_parser_chk.sv]
/* Port checker for bip_parser.
   Assumes one clock and the bind at the foot of this file. */
module bip_parser_chk #(
  parameter int W = 48
) (
  input wire logic         mclk,         // Clock.
  input wire logic         rst_n,        // Reset.
  input wire logic         in_valid,     // Byte offered.
  input wire logic [7:0]   in_byte,      // Byte.
  input wire logic         in_ready,     // Byte taken.
  input wire logic         blk_kind,     // Block kind.
  input wire logic         word_valid,   // Word out.
  input wire logic [W-1:0] word_data,    // Word.
  input wire logic         word_is_dmem, // Data word.
  input wire logic         word_ready,   // Word taken.
  input wire logic         blk_done,     // Block end.
  input wire logic         sum_err,      // Sum bad.
  input wire logic         fmt_err,      // Form bad.
  input wire logic         image_done    // Image end.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_wait;
    word_valid && !word_ready;
  endsequence
  sequence s_take;
    in_valid && in_ready;
  endsequence
  chk_coef_high_zero: assert property (word_valid && !word_is_dmem |-> !(|word_data[W-1:28]))
    else $error("coefficient word has bits above 27 set");
  chk_word_holds: assert property (s_wait |=> word_valid && $stable(word_data))
    else $error("word changed before it was taken");
  chk_kind_holds: assert property (s_wait |=> $stable(word_is_dmem))
    else $error("word kind changed before it was taken");
  chk_done_after_take: assert property (s_take ##1 blk_done |-> !$past(blk_done))
    else $error("block end repeated");
  chk_done_needs_byte: assert property (blk_done |-> $past(in_valid && in_ready))
    else $error("block end without a trailer byte");
  chk_sum_with_done: assert property (sum_err |-> blk_done)
    else $error("checksum error outside block end");
  chk_image_holds: assert property (image_done |=> image_done && !blk_done)
    else $error("image end dropped or block after it");
  chk_halt_after_img: assert property (image_done |-> !in_ready)
    else $error("bytes still taken after image end");
endmodule // bip_parser_chk

bind bip_parser bip_parser_chk #(.W(W)) chk_u (
  .mclk(mclk), .rst_n(rst_n), .in_valid(in_valid), .in_byte(in_byte),
  .in_ready(in_ready), .blk_kind(blk_kind), .word_valid(word_valid),
  .word_data(word_data), .word_is_dmem(word_is_dmem), .word_ready(word_ready),
  .blk_done(blk_done), .sum_err(sum_err), .fmt_err(fmt_err), .image_done(image_done)
);

// [tb/bip_img_mem.sv]
/* Serial memory holding the boot image, seen as a byte source.
   Assumes the bench fills mem and kind before raising go. */
module bip_img_mem (
  input  wire logic        mclk,     // Clock.
  input  wire logic        rst_n,    // Reset.
  input  wire logic        go,       // Start streaming.
  input  wire logic        slow,     // Random idle cycles.
  input  wire logic [15:0] img_len,  // Bytes stored.
  input  wire logic        in_ready, // Byte taken.
  output logic             in_valid, // Byte offered.
  output logic [7:0]       in_byte,  // Byte.
  output logic             blk_kind  // Block kind.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:1023];
  logic        kind [0:1023];
  logic [15:0] ptr;
  // An idle line shows a changing value so a stale byte is never mistaken for data.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr <= 16'h0000;
      in_valid <= 1'b0;
      in_byte <= 8'h00;
      blk_kind <= 1'b0;
    end else if (!in_valid || in_ready) begin
      if (go && ptr < img_len && !(slow && $urandom_range(2) == 0)) begin
        in_valid <= 1'b1;
        in_byte <= mem[ptr];
        blk_kind <= kind[ptr];
        ptr <= ptr + 16'h0001;
      end else begin
        in_valid <= 1'b0;
        in_byte <= ~in_byte;
      end
    end
  end
endmodule // bip_img_mem

// [tb/boot_image_block_parser_bench.sv]
/* Self-checking bench of bip_parser with a serial memory model.
   Assumes the checker is bound in from its own file. */
module boot_image_block_parser_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic hold = 1'b1;
  logic word_ready = 1'b0;
  logic in_valid, in_ready, blk_kind, word_valid, word_is_dmem;
  logic blk_done, sum_err, fmt_err, image_done;
  logic [7:0]  in_byte;
  logic [47:0] word_data;
  logic [48:0] exp_q[$];
  logic [15:0] len, base, sum;
  int err_count = 0;
  int tests_run = 0;
  int n_done, n_sum, n_fmt, e_done, e_sum, e_fmt;

  always #10 mclk = ~mclk;
  always @(posedge mclk) word_ready <= !hold && ($urandom_range(3) != 0);

  bip_img_mem mem_u (.mclk(mclk), .rst_n(rst_n), .go(go), .slow(slow), .img_len(len),
    .in_ready(in_ready), .in_valid(in_valid), .in_byte(in_byte), .blk_kind(blk_kind));
  bip_parser dut_u (.mclk(mclk), .rst_n(rst_n), .in_valid(in_valid), .in_byte(in_byte),
    .in_ready(in_ready), .blk_kind(blk_kind), .word_valid(word_valid),
    .word_data(word_data), .word_is_dmem(word_is_dmem), .word_ready(word_ready),
    .blk_done(blk_done), .sum_err(sum_err), .fmt_err(fmt_err), .image_done(image_done));

  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic stop_test();
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge mclk) begin
    if (rst_n !== 1'b1) begin
      n_done = 0;
      n_sum = 0;
      n_fmt = 0;
    end else begin
      if (word_valid === 1'b1 && word_ready === 1'b1) begin
        chk(exp_q.size() != 0 && {word_is_dmem, word_data} === exp_q[0], "word");
        if (exp_q.size() != 0) void'(exp_q.pop_front());
      end
      n_done += (blk_done === 1'b1);
      n_sum += (sum_err === 1'b1);
      n_fmt += (fmt_err === 1'b1);
    end
  end

  task automatic put(input logic [7:0] b, input logic k);
    mem_u.mem[len] = b;
    mem_u.kind[len] = k;
    if (len - base >= 16'h0002) sum = sum + 16'(b);
    len = len + 16'h0001;
  endtask

  task automatic block(input logic k, input int z, input logic [7:0] pad, input logic [15:0] skew);
    logic [47:0] w;
    logic [15:0] l;
    logic [15:0] s;
    int nb;
    nb = k ? 6 : 4;
    l = 16'(16 + nb * z);
    base = len;
    sum = 16'h0000;
    for (int i = 0; i < 12; i++) put((i == 8) ? l[15:8] : (i == 9) ? l[7:0] : (i < 8) ? 8'($urandom) : 8'h00, k);
    for (int j = 0; j < z; j++) begin
      w = 48'({$urandom, $urandom});
      for (int i = 0; i < nb; i++) put(w[8*i +: 8], k);
      exp_q.push_back({k, k ? w : {20'h00000, w[27:0]}});
    end
    s = sum + skew;
    put(pad, k);
    put(8'h00, k);
    put(s[15:8], k);
    put(s[7:0], k);
    e_done += 1;
    e_sum += (skew != 16'h0000);
    e_fmt += (pad != 8'h00);
  endtask

  task automatic term(input logic [7:0] bad);
    for (int i = 0; i < 20; i++) put((i == 3) ? 8'h1F : (i == 1) ? bad : 8'h00, 1'b0);
    e_fmt += (bad != 8'h00);
  endtask

  task automatic restart();
    rst_n <= 1'b0;
    go <= 1'b0;
    hold <= 1'b1;
    len = 16'h0000;
    e_done = 0;
    e_sum = 0;
    e_fmt = 0;
    exp_q.delete();
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
  endtask

  task automatic run(input bit full);
    go <= 1'b1;
    repeat (300) @(posedge mclk);
    if (full) chk(word_valid === 1'b1 && in_ready === 1'b0, "full buffer not refused");
    hold <= 1'b0;
    for (int t = 0; t < 20000 && !(image_done === 1'b1 && exp_q.size() == 0); t++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    chk(image_done === 1'b1 && in_ready === 1'b0, "termination not seen");
    chk(exp_q.size() == 0, "words missing");
    chk(n_sum == e_sum && n_fmt == e_fmt, "error pulse count");
    chk(n_done == e_done, "block count");
  endtask

  initial begin
    void'($urandom(32'hA8D1C811));
    restart();
    slow <= 1'b1;
    block(1'b0, 1, 8'h00, 16'h0000);
    block(1'b1, 12, 8'h00, 16'h0000);
    block(1'b0, 2 + $urandom_range(4), 8'h00, 16'h0001);
    block(1'b1, 1, 8'h00, 16'h0000);
    term(8'h00);
    run(1'b1);
    restart();
    slow <= 1'b0;
    block(1'b0, 2, 8'h5A, 16'h0000);
    term(8'h3C);
    run(1'b0);
    stop_test();
  end

  initial begin
    #(20 * 60000);
    err_count++;
    stop_test();
  end
endmodule // boot_image_block_parser_bench
